/* core/tsr_core.sv */
// System registers, protection guard and data space decoder.
`timescale 1ns/1ns
`default_nettype none
`include "tsr_defs.svh"

// Function
// - Protected registers accept writes only after the unlock signature.
// - Window stays open four instruction cycles, then closes itself.
// - Interrupts are ignored while the window is open.
// - Guard reads bit 0 as window open, bits 7 to 1 zero.
// - No interrupt is granted while global enable is clear.
// - Entry clears global enable; return and set instruction set it.
// - Sign flag always equals negative XOR overflow.
// - Bit store copies a bit to T; bit load copies T back.
// - ALU results update zero, negative, carry, half-carry, overflow.
// - Program counter is 9 bits, 16-bit words from zero.
// - Program memory reads through data space from byte 0x4000.
// - Stores into program memory region have no effect.
// - Lowest 64 addresses are I/O, next 32 are SRAM.
// - Lock, configuration, calibration, ID windows are read-only.
// - Direct load and store reach 0x0040 through 0x00BF only.
// - I/O instructions use I/O addresses zero through 0x3F.
// - Indirect access reaches all; pre-decrement and post-increment by one.
// - SRAM data access completes in two clock cycles.
// - Bit set, clear and test work on I/O up to 0x1F only.
// - Some flags clear on writing one; writing zero leaves them.
// - Stack pointer is two read-write bytes, reset to SRAM top.
// - Stack pointer moves by one on push/pop, two on call/return.
module tsr_core
    import tsr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire tsr_req_s    req,
    input  wire tsr_alu_s    alu,
    input  wire tsr_sp_e     sp_op,
    input  wire logic        irq_enter,
    input  wire logic        irq_return,
    input  wire logic        set_gie,
    input  wire logic        clr_gie,
    input  wire logic        bst_valid,
    input  wire logic        bld_valid,
    input  wire logic [7:0]  bit_src,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        instr_done,
    input  wire logic        irq_req,
    input  wire logic [7:0]  io_rdata,
    input  wire logic [15:0] prog_word,
    input  wire tsr_nvm_s    nvm,
    output var  tsr_rsp_s    rsp_r,
    output var  tsr_io_s     io_r,
    output var  logic [8:0]  prog_addr_r,
    output var  logic [15:0] ptr_next_r,
    output var  logic [15:0] sp_r,
    output var  logic [7:0]  status_r,
    output var  logic [7:0]  bld_res_r,
    output var  logic        prot_open_r,
    output var  logic        irq_grant_r
);

    // ==========================================================
    // Helpers.
    function automatic tsr_rgn_e rgn(input logic [15:0] a);
        if (a <= `TSR_IO_HI) return RG_IO;
        if (a >= `TSR_SRAM_LO && a <= `TSR_SRAM_HI) return RG_SRAM;
        if (a >= `TSR_LOCK_LO && a <= `TSR_LOCK_HI) return RG_LOCK;
        if (a >= `TSR_CFG_LO && a <= `TSR_CFG_HI) return RG_CFG;
        if (a >= `TSR_CAL_LO && a <= `TSR_CAL_HI) return RG_CAL;
        if (a >= `TSR_ID_LO && a <= `TSR_ID_HI) return RG_ID;
        if (a >= `TSR_FLASH_LO && a <= `TSR_FLASH_HI) return RG_FLASH;
        return RG_RSV;
    endfunction : rgn

    function automatic logic is_prot(input logic [5:0] a);
        return a == `TSR_CLKMS_ADDR || a == `TSR_CLKPS_ADDR ||
               a == `TSR_WDT_ADDR;
    endfunction : is_prot

    function automatic logic [7:0] mrg(input logic [7:0] o,
                                       input logic [7:0] v,
                                       input logic [7:0] m);
        return (o & ~m) | (v & m);
    endfunction : mrg

    // ==========================================================
    // Request decode.
    logic [15:0] acc_a;
    logic [15:0] ptr_upd;
    logic [7:0]  w_val;
    logic [7:0]  w_msk;
    logic        is_rd;
    logic        is_wr;
    logic        is_tst;
    logic        is_ind;
    tsr_rgn_e    rg;

    always_comb begin
        acc_a   = 16'h0000;
        ptr_upd = req.addr;
        w_val   = req.wdata;
        w_msk   = 8'hFF;
        is_rd   = 1'b0;
        is_wr   = 1'b0;
        is_tst  = 1'b0;
        is_ind  = 1'b0;
        unique case (req.kind)
            TSR_DLD, TSR_DST: begin
                acc_a = `TSR_DIRECT_BASE + {9'h000, req.addr[6:0]};
                is_rd = (req.kind == TSR_DLD);
                is_wr = (req.kind == TSR_DST);
            end
            TSR_ILD, TSR_IST: begin
                is_ind = 1'b1;
                is_rd  = (req.kind == TSR_ILD);
                is_wr  = (req.kind == TSR_IST);
                unique case (req.ptr_mode)
                    PTR_PREDEC: begin
                        acc_a   = req.addr - 16'h0001;
                        ptr_upd = acc_a;
                    end
                    PTR_POSTINC: begin
                        acc_a   = req.addr;
                        ptr_upd = req.addr + 16'h0001;
                    end
                    default: acc_a = req.addr;
                endcase
            end
            TSR_IN, TSR_OUT: begin
                acc_a = {10'h000, req.addr[5:0]};
                is_rd = (req.kind == TSR_IN);
                is_wr = (req.kind == TSR_OUT);
            end
            TSR_SBIT, TSR_CBIT: begin
                acc_a = {11'h000, req.addr[4:0]};
                is_wr = 1'b1;
                w_msk = 8'h01 << req.bitsel;
                w_val = (req.kind == TSR_SBIT) ? 8'hFF : 8'h00;
            end
            TSR_TBIT1, TSR_TBIT0: begin
                acc_a  = {11'h000, req.addr[4:0]};
                is_rd  = 1'b1;
                is_tst = 1'b1;
            end
            default: acc_a = 16'h0000;
        endcase
        rg = rgn(acc_a);
    end

    logic wr_go;
    logic rd_go;
    logic io_wr;
    logic int_hit;
    logic ccp_wr;
    logic status_flags_wr;
    logic sp_wr;

    assign wr_go   = req.valid && is_wr;
    assign rd_go   = req.valid && is_rd;
    assign io_wr   = wr_go && rg == RG_IO;
    assign int_hit = acc_a[5:0] == `TSR_SPL_ADDR ||
                     acc_a[5:0] == `TSR_SPH_ADDR ||
                     acc_a[5:0] == `TSR_STATUS_FLAGS_ADDR ||
                     acc_a[5:0] == `TSR_CCP_ADDR ||
                     acc_a[5:0] == `TSR_GSTAT_ADDR;
    assign ccp_wr  = io_wr && acc_a[5:0] == `TSR_CCP_ADDR;
    assign status_flags_wr = io_wr && acc_a[5:0] == `TSR_STATUS_FLAGS_ADDR;
    assign sp_wr   = io_wr && (acc_a[5:0] == `TSR_SPL_ADDR ||
                               acc_a[5:0] == `TSR_SPH_ADDR);

    // ==========================================================
    // Access pipeline: take, read stage, answer.
    logic [15:0] s1_addr_r, s1_addr_nxt;
    tsr_rgn_e    s1_rg_r, s1_rg_nxt;
    logic        s1_valid_r, s1_valid_nxt;
    logic        s1_tst_r, s1_tst_nxt;
    logic        s1_pol_r, s1_pol_nxt;
    logic [2:0]  s1_bit_r, s1_bit_nxt;
    tsr_io_s     io_nxt;
    tsr_rsp_s    rsp_nxt;
    logic [8:0]  prog_addr_nxt;
    logic [15:0] ptr_next_nxt;
    logic [7:0]  sram_rd;
    logic [7:0]  rd_v;
    logic        viol_r;

    tsr_sram u_sram (
        .mclk  (mclk),
        .we    (wr_go && rg == RG_SRAM),
        .waddr (acc_a[4:0]),
        .wdata (w_val),
        .raddr (s1_addr_r[4:0]),
        .rdata (sram_rd)
    );

    always_comb begin
        unique case (s1_rg_r)
            RG_IO: begin
                unique case (s1_addr_r[5:0])
                    `TSR_SPL_ADDR:   rd_v = sp_r[7:0];
                    `TSR_SPH_ADDR:   rd_v = sp_r[15:8];
                    `TSR_STATUS_FLAGS_ADDR:  rd_v = status_r;
                    `TSR_CCP_ADDR:   rd_v = {7'h00, prot_open_r};
                    `TSR_GSTAT_ADDR: rd_v = {7'h00, viol_r};
                    default:         rd_v = io_rdata;
                endcase
            end
            RG_SRAM:  rd_v = sram_rd;
            RG_LOCK:  rd_v = nvm.lock[{s1_addr_r[0], 3'h0} +: 8];
            RG_CFG:   rd_v = nvm.cfg[{s1_addr_r[0], 3'h0} +: 8];
            RG_CAL:   rd_v = nvm.cal[{s1_addr_r[0], 3'h0} +: 8];
            RG_ID:    rd_v = nvm.id[{s1_addr_r[1:0], 3'h0} +: 8];
            RG_FLASH: rd_v = prog_word[{s1_addr_r[0], 3'h0} +: 8];
            default:  rd_v = 8'h00;
        endcase
        s1_valid_nxt  = rd_go;
        s1_addr_nxt   = acc_a;
        s1_rg_nxt     = rg;
        s1_tst_nxt    = is_tst;
        s1_pol_nxt    = req.kind == TSR_TBIT1;
        s1_bit_nxt    = req.bitsel;
        io_nxt.addr   = acc_a[5:0];
        io_nxt.wdata  = w_val;
        io_nxt.wmask  = w_msk;
        io_nxt.rd     = rd_go && rg == RG_IO && !int_hit;
        io_nxt.wr     = io_wr && !int_hit &&
                        (!is_prot(acc_a[5:0]) || prot_open_r);
        prog_addr_nxt = (rd_go && rg == RG_FLASH) ?
                        acc_a[9:1] : prog_addr_r;
        ptr_next_nxt  = (req.valid && is_ind) ? ptr_upd : ptr_next_r;
        rsp_nxt.valid = s1_valid_r;
        rsp_nxt.rdata = rd_v;
        rsp_nxt.skip  = s1_valid_r && s1_tst_r &&
                        rd_v[s1_bit_r] == s1_pol_r;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_valid_r  <= 1'b0;
            s1_addr_r   <= 16'h0000;
            s1_rg_r     <= RG_RSV;
            s1_tst_r    <= 1'b0;
            s1_pol_r    <= 1'b0;
            s1_bit_r    <= 3'h0;
            io_r        <= '0;
            rsp_r       <= '0;
            prog_addr_r <= 9'h000;
            ptr_next_r  <= 16'h0000;
        end else begin
            s1_valid_r  <= s1_valid_nxt;
            s1_addr_r   <= s1_addr_nxt;
            s1_rg_r     <= s1_rg_nxt;
            s1_tst_r    <= s1_tst_nxt;
            s1_pol_r    <= s1_pol_nxt;
            s1_bit_r    <= s1_bit_nxt;
            io_r        <= io_nxt;
            rsp_r       <= rsp_nxt;
            prog_addr_r <= prog_addr_nxt;
            ptr_next_r  <= ptr_next_nxt;
        end
    end

    // ==========================================================
    // Status flags, stack pointer, bit copy, guard status.
    logic [7:0]  st_nxt;
    logic [15:0] sp_nxt;
    logic [7:0]  bld_nxt;
    logic        viol_nxt;

    always_comb begin
        st_nxt   = status_r;
        sp_nxt   = sp_r;
        bld_nxt  = bld_res_r;
        viol_nxt = viol_r;
        if (alu.valid) begin
            if (alu.upd_c) st_nxt[`TSR_BIT_C] = alu.c;
            if (alu.upd_z) st_nxt[`TSR_BIT_Z] = alu.res == 8'h00;
            if (alu.upd_n) st_nxt[`TSR_BIT_N] = alu.res[7];
            if (alu.upd_v) st_nxt[`TSR_BIT_V] = alu.v;
            if (alu.upd_h) st_nxt[`TSR_BIT_H] = alu.h;
        end
        if (bst_valid) st_nxt[`TSR_BIT_T] = bit_src[bit_sel];
        if (bld_valid) begin
            bld_nxt          = bit_src;
            bld_nxt[bit_sel] = status_r[`TSR_BIT_T];
        end
        if (irq_return || set_gie) st_nxt[`TSR_BIT_I] = 1'b1;
        if (irq_enter || clr_gie) st_nxt[`TSR_BIT_I] = 1'b0;
        unique case (sp_op)
            SP_PUSH1: sp_nxt = sp_r - 16'h0001;
            SP_POP1:  sp_nxt = sp_r + 16'h0001;
            SP_PUSH2: sp_nxt = sp_r - 16'h0002;
            SP_POP2:  sp_nxt = sp_r + 16'h0002;
            default:  sp_nxt = sp_r;
        endcase
        if (io_wr) begin
            unique case (acc_a[5:0])
                `TSR_SPL_ADDR: sp_nxt[7:0] = mrg(sp_r[7:0], w_val, w_msk);
                `TSR_SPH_ADDR: sp_nxt[15:8] = mrg(sp_r[15:8], w_val, w_msk);
                `TSR_STATUS_FLAGS_ADDR: st_nxt = mrg(status_r, w_val, w_msk);
                `TSR_GSTAT_ADDR: begin
                    if (w_val[0] && w_msk[0]) viol_nxt = 1'b0;
                end
                default: viol_nxt = viol_nxt;
            endcase
            if (is_prot(acc_a[5:0]) && !prot_open_r) begin
                viol_nxt = 1'b1;
            end
        end
        st_nxt[`TSR_BIT_S] = st_nxt[`TSR_BIT_N] ^ st_nxt[`TSR_BIT_V];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            status_r  <= `TSR_STATUS_FLAGS_RESET;
            sp_r      <= `TSR_SP_RESET;
            bld_res_r <= 8'h00;
            viol_r    <= 1'b0;
        end else begin
            status_r  <= st_nxt;
            sp_r      <= sp_nxt;
            bld_res_r <= bld_nxt;
            viol_r    <= viol_nxt;
        end
    end

    // ==========================================================
    // Configuration change guard and interrupt gate.
    logic [2:0] cnt_r, cnt_nxt;
    logic       open_nxt;
    logic       grant_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (instr_done && cnt_r != 3'h0) begin
            cnt_nxt = cnt_r - 3'h1;
        end
        if (ccp_wr) begin
            cnt_nxt = (w_val == `TSR_SIGNATURE) ?
                      `TSR_WIN_INSTR : 3'h0;
        end
        open_nxt  = cnt_nxt != 3'h0;
        grant_nxt = irq_req && status_r[`TSR_BIT_I] && !clr_gie &&
                    !prot_open_r;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r       <= 3'h0;
            prot_open_r <= 1'b0;
            irq_grant_r <= 1'b0;
        end else begin
            cnt_r       <= cnt_nxt;
            prot_open_r <= open_nxt;
            irq_grant_r <= grant_nxt;
        end
    end

    // ==========================================================
    // Assertions.
    logic bst_bit;
    logic alu_zero;
    logic ccp_sig;

    assign bst_bit  = bit_src[bit_sel];
    assign alu_zero = alu.res == 8'h00;
    assign ccp_sig  = ccp_wr && w_val == `TSR_SIGNATURE;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_ccp_open;
        ccp_sig |=> prot_open_r;
    endproperty
    a_ccp_open: assert property (p_ccp_open)
        else $error("Guard did not open after signature.");

    property p_prot_gate;
        io_r.wr && is_prot(io_r.addr) |-> $past(prot_open_r);
    endproperty
    a_prot_gate: assert property (p_prot_gate)
        else $error("Protected write passed with window closed.");

    property p_win_close;
        instr_done && !ccp_wr && cnt_r == 3'h1 |=> !prot_open_r;
    endproperty
    a_win_close: assert property (p_win_close)
        else $error("Window still open after four instructions.");

    property p_no_irq_win;
        irq_grant_r |-> !$past(prot_open_r);
    endproperty
    a_no_irq_win: assert property (p_no_irq_win)
        else $error("Interrupt granted inside guard window.");

    property p_gie;
        irq_grant_r |-> $past(status_r[`TSR_BIT_I]);
    endproperty
    a_gie: assert property (p_gie)
        else $error("Interrupt granted with global enable clear.");

    property p_entry;
        irq_enter && !status_flags_wr |=> !status_r[`TSR_BIT_I];
    endproperty
    a_entry: assert property (p_entry)
        else $error("Global enable not cleared on entry.");

    property p_sign;
        status_r[`TSR_BIT_S] ==
            (status_r[`TSR_BIT_N] ^ status_r[`TSR_BIT_V]);
    endproperty
    a_sign: assert property (p_sign)
        else $error("Sign flag differs from N xor V.");

    property p_bst;
        bst_valid && !status_flags_wr |=> status_r[`TSR_BIT_T] == $past(bst_bit);
    endproperty
    a_bst: assert property (p_bst)
        else $error("Bit store did not reach T.");

    property p_zero;
        alu.valid && alu.upd_z && !status_flags_wr
            |=> status_r[`TSR_BIT_Z] == $past(alu_zero);
    endproperty
    a_zero: assert property (p_zero)
        else $error("Zero flag wrong after ALU update.");

    property p_lat;
        rd_go |-> ##2 rsp_r.valid;
    endproperty
    a_lat: assert property (p_lat)
        else $error("Read answer not two cycles after request.");

    property p_push2;
        sp_op == SP_PUSH2 && !sp_wr |=> sp_r == $past(sp_r) - 16'h0002;
    endproperty
    a_push2: assert property (p_push2)
        else $error("Stack pointer not lowered by two.");

    c_unlock: cover property (ccp_sig ##1 io_r.wr);
    c_grant:  cover property (irq_grant_r);
    c_skip:   cover property (rsp_r.skip);

endmodule : tsr_core

`default_nettype wire

/* common/tsr_defs.svh */
// Address map, register offsets, field positions and reset values.
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// ==========================================================
// Data space map
`define TSR_IO_HI       16'h003F
`define TSR_SRAM_LO     16'h0040
`define TSR_SRAM_HI     16'h005F
`define TSR_LOCK_LO     16'h3F00
`define TSR_LOCK_HI     16'h3F01
`define TSR_CFG_LO      16'h3F40
`define TSR_CFG_HI      16'h3F41
`define TSR_CAL_LO      16'h3F80
`define TSR_CAL_HI      16'h3F81
`define TSR_ID_LO       16'h3FC0
`define TSR_ID_HI       16'h3FC3
`define TSR_FLASH_LO    16'h4000
`define TSR_FLASH_HI    16'h43FF
`define TSR_DIRECT_BASE 16'h0040

// ==========================================================
// I/O register offsets
`define TSR_SPL_ADDR    6'h3D
`define TSR_SPH_ADDR    6'h3E
`define TSR_STATUS_FLAGS_ADDR   6'h3F
`define TSR_CCP_ADDR    6'h3C
`define TSR_GSTAT_ADDR  6'h1E
`define TSR_CLKMS_ADDR  6'h37
`define TSR_CLKPS_ADDR  6'h36
`define TSR_WDT_ADDR    6'h31

// ==========================================================
// Status flag positions
`define TSR_BIT_I 7
`define TSR_BIT_T 6
`define TSR_BIT_H 5
`define TSR_BIT_S 4
`define TSR_BIT_V 3
`define TSR_BIT_N 2
`define TSR_BIT_Z 1
`define TSR_BIT_C 0

// ==========================================================
// Reset values and guard timing
`define TSR_SP_RESET    16'h005F
`define TSR_STATUS_FLAGS_RESET  8'h00
`define TSR_SIGNATURE   8'hD8
`define TSR_WIN_INSTR   3'h4

`endif

/* common/tsr_pkg.sv */
// Types shared by the system register and data space logic.
package tsr_pkg;

    typedef enum logic [3:0] {
        TSR_NOP   = 4'h0,
        TSR_DLD   = 4'h1,
        TSR_DST   = 4'h2,
        TSR_ILD   = 4'h3,
        TSR_IST   = 4'h4,
        TSR_IN    = 4'h5,
        TSR_OUT   = 4'h6,
        TSR_SBIT  = 4'h7,
        TSR_CBIT  = 4'h8,
        TSR_TBIT1 = 4'h9,
        TSR_TBIT0 = 4'hA
    } tsr_kind_e;

    typedef enum logic [1:0] {
        PTR_PLAIN   = 2'h0,
        PTR_PREDEC  = 2'h1,
        PTR_POSTINC = 2'h2
    } tsr_ptr_e;

    typedef enum logic [2:0] {
        SP_NONE  = 3'h0,
        SP_PUSH1 = 3'h1,
        SP_POP1  = 3'h2,
        SP_PUSH2 = 3'h3,
        SP_POP2  = 3'h4
    } tsr_sp_e;

    typedef enum logic [2:0] {
        RG_IO, RG_SRAM, RG_LOCK, RG_CFG, RG_CAL, RG_ID, RG_FLASH, RG_RSV
    } tsr_rgn_e;

    typedef struct packed {
        logic        valid;
        tsr_kind_e   kind;
        tsr_ptr_e    ptr_mode;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bitsel;
    } tsr_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
        logic       upd_c;
        logic       upd_z;
        logic       upd_n;
        logic       upd_v;
        logic       upd_h;
    } tsr_alu_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       skip;
    } tsr_rsp_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } tsr_io_s;

    typedef struct packed {
        logic [15:0] lock;
        logic [15:0] cfg;
        logic [15:0] cal;
        logic [31:0] id;
    } tsr_nvm_s;

endpackage : tsr_pkg

/* core/tsr_sram.sv */
// Internal 32-byte data SRAM with registered-address read.
`timescale 1ns/1ns
`default_nettype none

module tsr_sram
    import tsr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [4:0] raddr,
    output var  logic [7:0] rdata
);

    logic [7:0] mem [0:31];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : tsr_sram

`default_nettype wire

/* sim/tsr_far.sv */
// Far-side model: peripheral registers and program words.
`timescale 1ns/1ns
`default_nettype none

module tsr_far
    import tsr_pkg::*;
(
    input  wire logic        mclk,
    input  wire tsr_io_s     io,
    input  wire logic [8:0]  prog_addr,
    output var  logic [7:0]  io_rdata,
    output var  logic [15:0] prog_word
);
    logic [7:0] regs [64] = '{default: 8'h00};
    logic [7:0] last_r = 8'h00;

    // ==========================================================
    // Masked register writes.
    always @(posedge mclk) begin
        if (io.wr) begin
            regs[io.addr] <= (regs[io.addr] & ~io.wmask) |
                             (io.wdata & io.wmask);
        end
        if (io.rd) begin
            last_r <= regs[io.addr];
        end
    end

    // ==========================================================
    // Read data, inverted while no read is strobed.
    assign io_rdata = io.rd ? regs[io.addr] : ~last_r;
    assign prog_word = {7'h00, prog_addr} ^ 16'hC3A5;
endmodule : tsr_far

`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the data space core.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import tsr_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    tsr_req_s    req = '0;
    tsr_alu_s    alu = '0;
    tsr_sp_e     sp_op = SP_NONE;
    logic [6:0]  pul = '0;
    logic [7:0]  bit_src = '0, io_rdata, status_r, bld_res_r, d, mem[32];
    logic [2:0]  bit_sel = '0;
    logic        irq_req = 1'b0, prot_open_r, irq_grant_r;
    tsr_nvm_s    nvm;
    tsr_rsp_s    rsp_r;
    tsr_io_s     io_r;
    logic [8:0]  prog_addr_r, pw[3];
    logic [15:0] prog_word, ptr_next_r, sp_r, cyc = '0, a, pv;
    logic [95:0] rnd;
    logic [79:0] nvf;
    logic [7:0]  exp_q[$];
    logic [15:0] due_q[$];
    int          n_fail = 0, checks = 0, seed = 9;
    logic [15:0] nva[10] = '{16'h3F00, 16'h3F01, 16'h3F40, 16'h3F41, 16'h3F80,
                             16'h3F81, 16'h3FC0, 16'h3FC1, 16'h3FC2, 16'h3FC3};
    logic [15:0] rsv[4] = '{16'h0060, 16'h3F02, 16'h3FC4, 16'h4400};
    tsr_sp_e     spo[4] = '{SP_PUSH1, SP_PUSH2, SP_POP2, SP_POP1};
    logic [7:0]  spe[4] = '{8'h4F, 8'h4D, 8'h4F, 8'h50};
    logic [10:0] av[3] = '{{8'h80, 3'h1}, {8'h00, 3'h6}, {8'h40, 3'h1}};
    logic [5:0]  afl[3] = '{6'h0C, 6'h23, 6'h18};

    tsr_core u_dut (.mclk(mclk), .reset(reset), .req(req), .alu(alu),
        .sp_op(sp_op), .irq_enter(pul[6]), .irq_return(pul[5]),
        .set_gie(pul[4]), .clr_gie(pul[3]), .bst_valid(pul[2]),
        .bld_valid(pul[1]), .bit_src(bit_src), .bit_sel(bit_sel),
        .instr_done(pul[0]), .irq_req(irq_req), .io_rdata(io_rdata),
        .prog_word(prog_word), .nvm(nvm), .rsp_r(rsp_r), .io_r(io_r),
        .prog_addr_r(prog_addr_r), .ptr_next_r(ptr_next_r), .sp_r(sp_r),
        .status_r(status_r), .bld_res_r(bld_res_r),
        .prot_open_r(prot_open_r), .irq_grant_r(irq_grant_r));
    tsr_far u_far (.mclk(mclk), .io(io_r), .prog_addr(prog_addr_r),
        .io_rdata(io_rdata), .prog_word(prog_word));

    initial forever #20 mclk = ~mclk;
    always @(negedge mclk) cyc <= cyc + 16'h0001;

    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic op(tsr_kind_e k, logic [15:0] ad, logic [7:0] wd = 8'h00,
                      logic [7:0] e = 8'h00, tsr_ptr_e p = PTR_PLAIN);
        @(posedge mclk);
        req <= '{1'b1, k, p, ad, wd, 3'h0};
        if (k inside {TSR_DLD, TSR_ILD, TSR_IN}) begin
            exp_q.push_back(e);
            due_q.push_back(cyc + 16'h0002);
        end
    endtask : op

    task automatic idle(int n);
        @(posedge mclk) req.valid <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    task automatic pulse(logic [6:0] m);
        @(posedge mclk) {pul, req.valid} <= {m, 1'b0};
        @(posedge mclk) pul <= '0;
    endtask : pulse

    // ==========================================================
    // Answer checker.
    always @(negedge mclk) begin
        if (rsp_r.valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                chk(16'(rsp_r.rdata), 16'(exp_q.pop_front()));
                chk(cyc, due_q.pop_front());
            end else begin
                chk(16'h0001, 16'h0000);
            end
        end
    end

    initial begin
        #(40 * 3000);
        n_fail++;
        end_sim();
    end

    // ==========================================================
    // Main sequence.
    initial begin
        rnd = {$random(seed), $random(seed), $random(seed)};
        nvm = rnd[79:0];
        nvf = {nvm.id, nvm.cal, nvm.cfg, nvm.lock};
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        idle(1);
        chk(sp_r, 16'h005F);
        chk(16'(status_r), 16'h0000);
        op(TSR_IN, 16'h003D, 8'h00, 8'h5F);
        op(TSR_IN, 16'h003C);
        for (int i = 0; i < 32; i++) begin
            mem[i] = $random(seed);
            op(TSR_DST, 16'(i), mem[i]);
            op(TSR_ILD, 16'(i + 64), 8'h00, mem[i]);
        end
        op(TSR_DLD, 16'h0005, 8'h00, mem[5]);
        op(TSR_DLD, 16'h007F);
        foreach (rsv[i]) begin
            op(TSR_IST, rsv[i], 8'hFF);
            op(TSR_ILD, rsv[i]);
        end
        foreach (nva[i]) begin
            op(TSR_IST, nva[i], ~nvf[8*i +: 8]);
            op(TSR_ILD, nva[i], 8'h00, nvf[8*i +: 8]);
        end
        pw = '{9'h000, 9'h1FF, 9'h000};
        pw[2] = 9'($random(seed));
        foreach (pw[i]) begin
            a = 16'h4000 + {6'h00, pw[i], 1'b0};
            pv = {7'h00, pw[i]} ^ 16'hC3A5;
            op(TSR_IST, a, ~pv[7:0]);
            op(TSR_ILD, a, 8'h00, pv[7:0]);
            op(TSR_ILD, a + 16'h0001, 8'h00, pv[15:8]);
        end
        op(TSR_IST, 16'h0045, 8'h00, 8'h00, PTR_POSTINC);
        idle(1);
        chk(ptr_next_r, 16'h0046);
        op(TSR_IST, 16'h0045, 8'h00, 8'h00, PTR_PREDEC);
        idle(1);
        chk(ptr_next_r, 16'h0044);
        irq_req <= 1'b1;
        pulse(7'h10);
        idle(2);
        chk(16'(status_r[7]), 16'h0001);
        chk(16'(irq_grant_r), 16'h0001);
        op(TSR_OUT, 16'h003C, 8'hD8);
        idle(2);
        chk(16'(prot_open_r), 16'h0001);
        chk(16'(irq_grant_r), 16'h0000);
        op(TSR_OUT, 16'h0037, 8'hA5);
        op(TSR_IN, 16'h0037, 8'h00, 8'hA5);
        op(TSR_IN, 16'h003C, 8'h00, 8'h01);
        repeat (3) pulse(7'h01);
        idle(1);
        chk(16'(prot_open_r), 16'h0001);
        pulse(7'h01);
        idle(2);
        chk(16'(prot_open_r), 16'h0000);
        chk(16'(irq_grant_r), 16'h0001);
        op(TSR_OUT, 16'h0037, 8'h3C);
        op(TSR_IN, 16'h0037, 8'h00, 8'hA5);
        op(TSR_OUT, 16'h001E);
        op(TSR_IN, 16'h001E, 8'h00, 8'h01);
        op(TSR_OUT, 16'h001E, 8'h01);
        op(TSR_IN, 16'h001E);
        op(TSR_OUT, 16'h003C, 8'hD8);
        op(TSR_OUT, 16'h003C, 8'h55);
        idle(2);
        chk(16'(prot_open_r), 16'h0000);
        pulse(7'h08);
        idle(1);
        chk(16'(irq_grant_r), 16'h0000);
        chk(16'(status_r[7]), 16'h0000);
        pulse(7'h20);
        idle(1);
        chk(16'(status_r[7]), 16'h0001);
        pulse(7'h40);
        idle(1);
        chk(16'(status_r[7]), 16'h0000);
        op(TSR_OUT, 16'h003D, 8'h50);
        op(TSR_OUT, 16'h003E);
        op(TSR_IN, 16'h003D, 8'h00, 8'h50);
        idle(3);
        foreach (spo[i]) begin
            @(posedge mclk) sp_op <= spo[i];
            @(posedge mclk) sp_op <= SP_NONE;
            @(negedge mclk) chk(sp_r, {8'h00, spe[i]});
        end
        foreach (av[i]) begin
            @(posedge mclk) alu <= {1'b1, av[i], 5'h1F};
            @(posedge mclk) alu <= '0;
            @(negedge mclk) chk(16'(status_r[5:0]), 16'(afl[i]));
        end
        d = $random(seed);
        @(posedge mclk) begin
            bit_src <= d;
            bit_sel <= 3'h5;
        end
        pulse(7'h04);
        idle(1);
        chk(16'(status_r[6]), 16'(d[5]));
        @(posedge mclk) bit_src <= ~d;
        pulse(7'h02);
        idle(1);
        chk(16'(bld_res_r), 16'({~d[7:6], d[5], ~d[4:0]}));
        @(posedge mclk) req <= '{1'b1, TSR_SBIT, PTR_PLAIN, 16'h5, 8'h0, 3'h6};
        @(posedge mclk) req.valid <= 1'b0;
        @(negedge mclk) chk(16'(io_r.wmask), 16'h0040);
        idle(4);
        chk(16'(exp_q.size()), 16'h0000);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
